//--- sim/adm_host_model.sv
// Host controller model that drives the register strobe port
`timescale 1ns/1ns
module adm_host_model (
  input wire logic core_clk_in,
  input wire logic [7:0] rdata_in,
  input wire logic rvalid_in,
  output logic wr_en_out,
  output logic rd_en_out,
  output logic [6:0] index_out,
  output logic [7:0] wdata_out
);
  initial
  begin
    wr_en_out = 1'b0;
    rd_en_out = 1'b0;
    index_out = 7'h00;
    wdata_out = 8'h00;
  end

  // Released lines show inverted data so a stale value never matches
  task automatic write_reg(input logic [6:0] idx, input logic [7:0] d);
    @(posedge core_clk_in);
    #1;
    wr_en_out = 1'b1;
    index_out = idx;
    wdata_out = d;
    @(posedge core_clk_in);
    #1;
    wr_en_out = 1'b0;
    index_out = ~idx;
    wdata_out = ~d;
  endtask : write_reg

  task automatic read_reg(input logic [6:0] idx, output logic [7:0] d,
                          output logic v);
    @(posedge core_clk_in);
    #1;
    rd_en_out = 1'b1;
    index_out = idx;
    @(posedge core_clk_in);
    #1;
    rd_en_out = 1'b0;
    index_out = ~idx;
    d = rdata_in;
    v = rvalid_in;
  endtask : read_reg
endmodule : adm_host_model

//--- sim/adm_mode_regs_test.sv
// Self-checking bench for the mode-control register bank
`timescale 1ns/1ns
module adm_mode_regs_test;
  import adm_pkg::*;
  // Strap value is arbitrary
  localparam logic [4:0] UNIT_ID = 5'h0B;
  localparam logic [7:0] RST_EXP [0:7] = '{8'hFF, 8'hFF, 8'h50, 8'h00,
                                          8'h00, 8'h01, 8'h00, {3'h0, UNIT_ID}};
  logic core_clk_in = 1'b0;
  logic rstn_in = 1'b0;
  logic fs_tick_in = 1'b0;
  logic left_zero_in = 1'b0;
  logic right_zero_in = 1'b0;
  logic [4:0] unit_identifier_in = UNIT_ID;
  logic reg_wr_en_in, reg_rd_en_in, reg_rvalid_out;
  logic [6:0] reg_index_in;
  logic [7:0] reg_wdata_in, reg_rdata_out;
  logic [7:0] left_atten_level_out, right_atten_level_out;
  logic left_mute_out, right_mute_out, deemph_enable_out;
  logic output_phase_invert_out, converter_disable_out;
  logic bypass_stereo_sel_out, rolloff_sel_out, infinite_zero_mute_en_out;
  logic soft_system_reset_out, single_channel_mode_out;
  logic single_channel_source_out, multibit_zero_out_en_out;
  logic [2:0] input_format_sel_out;
  logic [1:0] deemph_rate_sel_out, fir_perf_sel_out, fir_rate_sel_out;
  logic [1:0] oversample_rate_sel_out, bitstream_zero_out_ctrl_out;
  adm_mode_t iface_mode_out;
  int err_total = 0;
  int checked = 0;

  always #2 core_clk_in = ~core_clk_in;

  adm_mode_regs dut_u (
    .core_clk_in, .rstn_in, .reg_wr_en_in, .reg_rd_en_in, .reg_index_in,
    .reg_wdata_in, .reg_rdata_out, .reg_rvalid_out, .fs_tick_in,
    .left_zero_in, .right_zero_in, .unit_identifier_in,
    .left_atten_level_out, .right_atten_level_out, .left_mute_out,
    .right_mute_out, .input_format_sel_out, .deemph_enable_out,
    .deemph_rate_sel_out, .fir_perf_sel_out, .output_phase_invert_out,
    .converter_disable_out, .bypass_stereo_sel_out, .rolloff_sel_out,
    .infinite_zero_mute_en_out, .soft_system_reset_out, .iface_mode_out,
    .single_channel_mode_out, .single_channel_source_out,
    .oversample_rate_sel_out, .fir_rate_sel_out, .multibit_zero_out_en_out,
    .bitstream_zero_out_ctrl_out
  );

  adm_host_model host_u (
    .core_clk_in(core_clk_in),
    .rdata_in(reg_rdata_out),
    .rvalid_in(reg_rvalid_out),
    .wr_en_out(reg_wr_en_in),
    .rd_en_out(reg_rd_en_in),
    .index_out(reg_index_in),
    .wdata_out(reg_wdata_in)
  );

  task automatic chk(input string what, input logic [23:0] exp,
                     input logic [23:0] got);
    checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [6:0] idx, input logic [7:0] d);
    host_u.write_reg(idx, d);
    repeat (2) @(posedge core_clk_in);
    #1;
  endtask : wr

  task automatic rd_chk(input logic [6:0] idx, input logic [7:0] exp);
    logic [7:0] d;
    logic v;
    host_u.read_reg(idx, d, v);
    chk("rvalid", 24'h1, {23'h0, v});
    chk("rdata", {16'h0, exp}, {16'h0, d});
  endtask : rd_chk

  // Each tick is one fs pulse followed by one idle cycle
  task automatic tick(input int n);
    repeat (n)
    begin
      @(posedge core_clk_in);
      #1;
      fs_tick_in = 1'b1;
      @(posedge core_clk_in);
      #1;
      fs_tick_in = 1'b0;
    end
  endtask : tick

  task automatic lvl(input logic [7:0] l, input logic [7:0] r);
    chk("levels", {8'h0, l, r}, {8'h0, left_atten_level_out,
        right_atten_level_out});
  endtask : lvl

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : print_verdict

  initial
  begin
    #100000;
    err_total++;
    print_verdict();
  end

  initial
  begin
    logic [7:0] m;
    logic bs, byp, pcm;
    repeat (6) @(posedge core_clk_in);
    #1;
    rstn_in = 1'b1;
    repeat (2) @(posedge core_clk_in);
    #1;
    chk("rst outs", 24'hFF0501, {left_atten_level_out, 4'h0,
        1'b0, input_format_sel_out, 7'h0, multibit_zero_out_en_out});
    for (int i = 0; i < 8; i++)
      rd_chk(ADM_IDX_LEFT_ATT + 7'(i), RST_EXP[i]);
    rd_chk(7'h20, 8'h00);
    wr(ADM_IDX_SPEED_CTRL, 8'hFF);
    wr(ADM_IDX_MODE_CTRL, 8'hFF);
    wr(ADM_IDX_ZERO_CTRL, 8'hFF);
    wr(ADM_IDX_ZERO_FLAG, 8'hAA);
    wr(ADM_IDX_UNIT_ID, 8'hAA);
    rd_chk(ADM_IDX_SPEED_CTRL, 8'hF7);
    rd_chk(ADM_IDX_MODE_CTRL, 8'h7F);
    rd_chk(ADM_IDX_ZERO_CTRL, 8'h07);
    rd_chk(ADM_IDX_ZERO_FLAG, 8'h00);
    rd_chk(ADM_IDX_UNIT_ID, {3'h0, UNIT_ID});
    chk("sys ctl", 24'h7, {21'h0, soft_system_reset_out,
        single_channel_mode_out, single_channel_source_out});
    wr(ADM_IDX_MODE_CTRL, 8'h00);
    wr(ADM_IDX_SPEED_CTRL, 8'h00);
    wr(ADM_IDX_ZERO_CTRL, 8'h01);
    // Loads held while the load bit is clear
    wr(ADM_IDX_LEFT_ATT, 8'hFC);
    tick(3);
    lvl(8'hFF, 8'hFF);
    rd_chk(ADM_IDX_LEFT_ATT, 8'hFC);
    wr(ADM_IDX_FMT_CTRL, 8'hD0);
    tick(1);
    lvl(8'hFE, 8'hFF);
    tick(1);
    lvl(8'hFD, 8'hFF);
    tick(2);
    lvl(8'hFC, 8'hFF);
    wr(ADM_IDX_SPEED_CTRL, 8'h60);
    wr(ADM_IDX_LEFT_ATT, 8'hF0);
    tick(8);
    lvl(8'hFB, 8'hFF);
    tick(8);
    lvl(8'hFA, 8'hFF);
    wr(ADM_IDX_SPEED_CTRL, 8'h20);
    tick(1);
    lvl(8'hFA, 8'hFF);
    tick(1);
    lvl(8'hF9, 8'hFF);
    wr(ADM_IDX_SPEED_CTRL, 8'h40);
    tick(3);
    lvl(8'hF9, 8'hFF);
    tick(1);
    lvl(8'hF8, 8'hFF);
    wr(ADM_IDX_SPEED_CTRL, 8'h00);
    wr(ADM_IDX_LEFT_ATT, 8'h0F);
    tick(233);
    lvl(8'h0F, 8'hFF);
    chk("mute 0F", 24'h0, {23'h0, left_mute_out});
    wr(ADM_IDX_LEFT_ATT, 8'h0E);
    tick(1);
    chk("mute 0E", 24'h1, {23'h0, left_mute_out});
    wr(ADM_IDX_FMT_CTRL, 8'hD1);
    tick(14);
    lvl(8'h00, 8'hF1);
    wr(ADM_IDX_FMT_CTRL, 8'hD0);
    wr(ADM_IDX_LEFT_ATT, 8'hFF);
    tick(255);
    lvl(8'hFF, 8'hFF);
    wr(ADM_IDX_FMT_CTRL, 8'hD1);
    tick(254);
    lvl(8'h01, 8'h01);
    tick(1);
    lvl(8'h00, 8'h00);
    chk("mute lr", 24'h3, {22'h0, left_mute_out, right_mute_out});
    // Mode decode across all interface selections
    wr(ADM_IDX_FMT_CTRL, 8'h5E);
    wr(ADM_IDX_SPEED_CTRL, 8'h97);
    wr(ADM_IDX_ZERO_CTRL, 8'h07);
    for (int i = 0; i < 4; i++)
    begin
      m = 8'h02 | 8'(i << 4);
      wr(ADM_IDX_MODE_CTRL, m);
      bs = m[5];
      byp = !m[5] && m[4];
      pcm = !m[5] && !m[4];
      chk("mode outs", {2'h0, 3'h5, 2'h3, bs, byp, pcm, {2{pcm}}, {2{bs}},
          byp, pcm, pcm | byp, !bs, {2{bs}}, !bs, 1'b0, bs, 1'b0},
          {2'h0, input_format_sel_out, output_phase_invert_out,
          converter_disable_out, iface_mode_out, deemph_enable_out,
          deemph_rate_sel_out, fir_perf_sel_out, bypass_stereo_sel_out,
          rolloff_sel_out, infinite_zero_mute_en_out,
          multibit_zero_out_en_out, bitstream_zero_out_ctrl_out,
          oversample_rate_sel_out,
          fir_rate_sel_out});
    end
    left_zero_in = 1'b1;
    rd_chk(ADM_IDX_ZERO_FLAG, 8'h01);
    right_zero_in = 1'b1;
    rd_chk(ADM_IDX_ZERO_FLAG, 8'h03);
    print_verdict();
  end
endmodule : adm_mode_regs_test

//--- src/adm_atten_ramp.sv
// One channel attenuator that steps toward its target level
`timescale 1ns/1ns
module adm_atten_ramp
  import adm_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic rstn_in,
  input wire logic step_in,
  input wire logic active_in,
  input wire logic [7:0] target_in,
  output logic [7:0] level_out,
  output logic mute_out
);
  logic [7:0] level_q;
  logic [7:0] level_d;
  logic mute_q;

  // Outside PCM mode the attenuator sits at 0 dB
  always_comb
  begin
    level_d = level_q;
    if (!active_in)
    begin
      level_d = ADM_ATT_FULL;
    end
    else if (step_in && level_q < target_in)
    begin
      level_d = level_q + 8'h01;
    end
    else if (step_in && level_q > target_in)
    begin
      level_d = level_q - 8'h01;
    end
  end

  always_ff @(posedge core_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      level_q <= ADM_ATT_FULL;
      mute_q <= 1'b0;
    end
    else
    begin
      level_q <= level_d;
      mute_q <= (level_d <= ADM_ATT_MUTE_MAX);
    end
  end

  assign level_out = level_q;
  assign mute_out = mute_q;
endmodule : adm_atten_ramp

//--- src/adm_mode_regs.sv
// Mode-control register bank of the stereo audio converter
`timescale 1ns/1ns
module adm_mode_regs
  import adm_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic rstn_in,
  input wire logic reg_wr_en_in,
  input wire logic reg_rd_en_in,
  input wire logic [6:0] reg_index_in,
  input wire logic [7:0] reg_wdata_in,
  output logic [7:0] reg_rdata_out,
  output logic reg_rvalid_out,
  input wire logic fs_tick_in,
  input wire logic left_zero_in,
  input wire logic right_zero_in,
  input wire logic [4:0] unit_identifier_in,
  output logic [7:0] left_atten_level_out,
  output logic [7:0] right_atten_level_out,
  output logic left_mute_out,
  output logic right_mute_out,
  output logic [2:0] input_format_sel_out,
  output logic deemph_enable_out,
  output logic [1:0] deemph_rate_sel_out,
  output logic [1:0] fir_perf_sel_out,
  output logic output_phase_invert_out,
  output logic converter_disable_out,
  output logic bypass_stereo_sel_out,
  output logic rolloff_sel_out,
  output logic infinite_zero_mute_en_out,
  output logic soft_system_reset_out,
  output adm_pkg::adm_mode_t iface_mode_out,
  output logic single_channel_mode_out,
  output logic single_channel_source_out,
  output logic [1:0] oversample_rate_sel_out,
  output logic [1:0] fir_rate_sel_out,
  output logic multibit_zero_out_en_out,
  output logic [1:0] bitstream_zero_out_ctrl_out
);
  import adm_pkg::*;

  // Divider count at which an attenuation step fires; a step comes every count+1 fs ticks
  function automatic logic [2:0] step_div_max(input logic [1:0] rate);
    logic [2:0] m;
    m = 3'h0;
    case (rate)
      2'b00: m = 3'h0;
      2'b01: m = 3'h1;
      2'b10: m = 3'h3;
      default: m = 3'h7;
    endcase
    return m;
  endfunction : step_div_max

  function automatic logic idx_hit(input logic [6:0] idx,
                                   input logic [6:0] off);
    return idx == off;
  endfunction : idx_hit

  logic [7:0] att_q [0:1];
  logic [7:0] fmt_q;
  logic [7:0] speed_q;
  logic [7:0] mode_q;
  logic [7:0] zctl_q;
  logic [1:0] zero_flag_q;
  logic [4:0] unit_id_q;
  logic id_taken_q;
  logic [7:0] tgt_q [0:1];
  logic [2:0] div_q;
  logic [7:0] rdata_q;
  logic rvalid_q;
  logic [7:0] level [0:1];
  logic mute_lvl [0:1];

  logic [2:0] fmt_o_q;
  logic dme_o_q;
  logic [1:0] dmf_o_q;
  logic [1:0] fir_perf_o_q;
  logic rev_o_q;
  logic ope_o_q;
  logic bypass_stereo_sel_o_q;
  logic flt_o_q;
  logic infinite_zero_mute_en_o_q;
  logic soft_system_reset_o_q;
  adm_mode_t mode_o_q;
  logic single_channel_mode_o_q;
  logic single_channel_source_o_q;
  logic [1:0] os_o_q;
  logic [1:0] fir_rate_o_q;
  logic multibit_zero_out_en_o_q;
  logic [1:0] dz_o_q;

  // Write strobes per register; read-only and unmapped indices ignored
  wire wr_left = reg_wr_en_in && idx_hit(reg_index_in, ADM_IDX_LEFT_ATT);
  wire wr_right = reg_wr_en_in && idx_hit(reg_index_in, ADM_IDX_RIGHT_ATT);
  wire wr_fmt = reg_wr_en_in && idx_hit(reg_index_in, ADM_IDX_FMT_CTRL);
  wire wr_speed = reg_wr_en_in && idx_hit(reg_index_in, ADM_IDX_SPEED_CTRL);
  wire wr_mode = reg_wr_en_in && idx_hit(reg_index_in, ADM_IDX_MODE_CTRL);
  wire wr_zctl = reg_wr_en_in && idx_hit(reg_index_in, ADM_IDX_ZERO_CTRL);

  // Field decode
  wire atten_load_enable = fmt_q[ADM_B_ATTEN_LOAD_ENABLE];
  wire [2:0] fmt_f = fmt_q[ADM_B_FMT_LO +: 3];
  wire [1:0] dmf_f = fmt_q[ADM_B_DMF_LO +: 2];
  wire dme_f = fmt_q[ADM_B_DME];
  wire mute_f = fmt_q[ADM_B_MUTE];
  wire [1:0] ats_f = speed_q[ADM_B_ATS_LO +: 2];
  wire dsd_f = mode_q[ADM_B_DSD];
  wire filter_bypass_en_f = mode_q[ADM_B_FILTER_BYPASS_EN];
  wire [1:0] os_f = mode_q[ADM_B_OS_LO +: 2];

  // Bitstream mode takes precedence over filter bypass
  wire is_bits = dsd_f;
  wire is_byp = !dsd_f && filter_bypass_en_f;
  wire is_pcm = !dsd_f && !filter_bypass_en_f;
  wire pcm_or_byp = !is_bits;
  wire adm_mode_t mode_sel = is_bits ? ADM_MODE_BITSTREAM :
                             (is_byp ? ADM_MODE_BYPASS : ADM_MODE_PCM);

  // Attenuation step strobe derived from the sample-rate tick
  wire step_tick = fs_tick_in && (div_q == step_div_max(ats_f));
  wire soft_mute_act = mute_f && is_pcm;

  // Read mux; indices without a register read as zero
  wire [7:0] rd_sel =
    idx_hit(reg_index_in, ADM_IDX_LEFT_ATT) ? att_q[0] :
    idx_hit(reg_index_in, ADM_IDX_RIGHT_ATT) ? att_q[1] :
    idx_hit(reg_index_in, ADM_IDX_FMT_CTRL) ? fmt_q :
    idx_hit(reg_index_in, ADM_IDX_SPEED_CTRL) ? speed_q :
    idx_hit(reg_index_in, ADM_IDX_MODE_CTRL) ? mode_q :
    idx_hit(reg_index_in, ADM_IDX_ZERO_CTRL) ? zctl_q :
    idx_hit(reg_index_in, ADM_IDX_ZERO_FLAG) ? {6'h00, zero_flag_q} :
    idx_hit(reg_index_in, ADM_IDX_UNIT_ID) ? {3'h0, unit_id_q} :
    8'h00;

  // Host-visible register storage
  always_ff @(posedge core_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      att_q[0] <= ADM_RST_ATT;
      att_q[1] <= ADM_RST_ATT;
      fmt_q <= ADM_RST_FMT_CTRL;
      speed_q <= ADM_RST_SPEED_CTRL;
      mode_q <= ADM_RST_MODE_CTRL;
      zctl_q <= ADM_RST_ZERO_CTRL;
    end
    else
    begin
      if (wr_left)
      begin
        att_q[0] <= reg_wdata_in;
      end
      if (wr_right)
      begin
        att_q[1] <= reg_wdata_in;
      end
      if (wr_fmt)
      begin
        fmt_q <= reg_wdata_in;
      end
      if (wr_speed)
      begin
        speed_q <= reg_wdata_in & ADM_MASK_SPEED_CTRL;
      end
      if (wr_mode)
      begin
        mode_q <= reg_wdata_in & ADM_MASK_MODE_CTRL;
      end
      if (wr_zctl)
      begin
        zctl_q <= reg_wdata_in & ADM_MASK_ZERO_CTRL;
      end
    end
  end

  // Zero flags follow the detectors; unit id is caught after reset release
  always_ff @(posedge core_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      zero_flag_q <= 2'b00;
      unit_id_q <= ADM_RST_UNIT_ID;
      id_taken_q <= 1'b0;
    end
    else
    begin
      zero_flag_q <= {right_zero_in, left_zero_in};
      id_taken_q <= 1'b1;
      if (!id_taken_q)
      begin
        unit_id_q <= unit_identifier_in;
      end
    end
  end

  // Applied attenuation targets follow the registers only while loading
  always_ff @(posedge core_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      tgt_q[0] <= ADM_RST_ATT;
      tgt_q[1] <= ADM_RST_ATT;
    end
    else if (atten_load_enable)
    begin
      tgt_q[0] <= att_q[0];
      tgt_q[1] <= att_q[1];
    end
  end

  // Sample-tick divider for the step rate
  always_ff @(posedge core_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      div_q <= 3'h0;
    end
    else if (step_tick)
    begin
      div_q <= 3'h0;
    end
    else if (fs_tick_in)
    begin
      div_q <= div_q + 3'h1;
    end
  end

  // Per-channel attenuators; soft mute drives the target to the floor
  generate
    for (genvar ch = 0; ch < 2; ch++)
    begin : g_chan
      wire [7:0] ramp_tgt = soft_mute_act ? ADM_ATT_FLOOR : tgt_q[ch];
      adm_atten_ramp u_ramp (
        .core_clk_in(core_clk_in),
        .rstn_in(rstn_in),
        .step_in(step_tick),
        .active_in(is_pcm),
        .target_in(ramp_tgt),
        .level_out(level[ch]),
        .mute_out(mute_lvl[ch])
      );
    end
  endgenerate

  // Effective controls; a field idle in the current mode drives its
  // neutral value but keeps its stored contents
  always_ff @(posedge core_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      fmt_o_q <= ADM_RST_FMT_CTRL[ADM_B_FMT_LO +: 3];
      dme_o_q <= 1'b0;
      dmf_o_q <= 2'b00;
      fir_perf_o_q <= 2'b00;
      rev_o_q <= 1'b0;
      ope_o_q <= 1'b0;
      bypass_stereo_sel_o_q <= 1'b0;
      flt_o_q <= 1'b0;
      infinite_zero_mute_en_o_q <= 1'b0;
      soft_system_reset_o_q <= 1'b0;
      mode_o_q <= ADM_MODE_PCM;
      single_channel_mode_o_q <= 1'b0;
      single_channel_source_o_q <= 1'b0;
      os_o_q <= 2'b00;
      fir_rate_o_q <= 2'b00;
      multibit_zero_out_en_o_q <= ADM_RST_ZERO_CTRL[ADM_B_MULTIBIT_ZERO_OUT_EN];
      dz_o_q <= 2'b00;
    end
    else
    begin
      fmt_o_q <= fmt_f;
      dme_o_q <= dme_f && is_pcm;
      dmf_o_q <= is_pcm ? dmf_f : 2'b00;
      fir_perf_o_q <= is_bits ? dmf_f : 2'b00;
      rev_o_q <= speed_q[ADM_B_REV];
      ope_o_q <= speed_q[ADM_B_OPE];
      bypass_stereo_sel_o_q <= speed_q[ADM_B_BYPASS_STEREO_SEL] && is_byp;
      flt_o_q <= speed_q[ADM_B_FLT] && is_pcm;
      infinite_zero_mute_en_o_q <= speed_q[ADM_B_INFINITE_ZERO_MUTE_EN] && pcm_or_byp;
      soft_system_reset_o_q <= mode_q[ADM_B_SOFT_SYSTEM_RESET];
      mode_o_q <= mode_sel;
      single_channel_mode_o_q <= mode_q[ADM_B_SINGLE_CHANNEL_MODE];
      single_channel_source_o_q <= mode_q[ADM_B_SINGLE_CHANNEL_SOURCE];
      os_o_q <= is_bits ? 2'b00 : os_f;
      fir_rate_o_q <= is_bits ? os_f : 2'b00;
      multibit_zero_out_en_o_q <= zctl_q[ADM_B_MULTIBIT_ZERO_OUT_EN] && pcm_or_byp;
      dz_o_q <= is_bits ? zctl_q[ADM_B_DZ_LO +: 2] : 2'b00;
    end
  end

  // Read port answers one cycle after the strobe
  always_ff @(posedge core_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      rdata_q <= 8'h00;
      rvalid_q <= 1'b0;
    end
    else
    begin
      rvalid_q <= reg_rd_en_in;
      if (reg_rd_en_in)
      begin
        rdata_q <= rd_sel;
      end
    end
  end

  assign reg_rdata_out = rdata_q;
  assign reg_rvalid_out = rvalid_q;
  assign left_atten_level_out = level[0];
  assign right_atten_level_out = level[1];
  assign left_mute_out = mute_lvl[0];
  assign right_mute_out = mute_lvl[1];
  assign input_format_sel_out = fmt_o_q;
  assign deemph_enable_out = dme_o_q;
  assign deemph_rate_sel_out = dmf_o_q;
  assign fir_perf_sel_out = fir_perf_o_q;
  assign output_phase_invert_out = rev_o_q;
  assign converter_disable_out = ope_o_q;
  assign bypass_stereo_sel_out = bypass_stereo_sel_o_q;
  assign rolloff_sel_out = flt_o_q;
  assign infinite_zero_mute_en_out = infinite_zero_mute_en_o_q;
  assign soft_system_reset_out = soft_system_reset_o_q;
  assign iface_mode_out = mode_o_q;
  assign single_channel_mode_out = single_channel_mode_o_q;
  assign single_channel_source_out = single_channel_source_o_q;
  assign oversample_rate_sel_out = os_o_q;
  assign fir_rate_sel_out = fir_rate_o_q;
  assign multibit_zero_out_en_out = multibit_zero_out_en_o_q;
  assign bitstream_zero_out_ctrl_out = dz_o_q;

  a_atten_load_enable_hold: assert property (@(posedge core_clk_in)
    disable iff (!rstn_in) !atten_load_enable |=> $stable(tgt_q[0]))
    else $error("attenuation target moved while load disabled");

  a_atten_load_enable_load: assert property (@(posedge core_clk_in)
    disable iff (!rstn_in) atten_load_enable |=> tgt_q[1] == $past(att_q[1]))
    else $error("attenuation target not loaded");

  a_read_left: assert property (@(posedge core_clk_in)
    disable iff (!rstn_in)
    reg_rd_en_in && reg_index_in == ADM_IDX_LEFT_ATT
    |=> reg_rvalid_out && reg_rdata_out == $past(att_q[0]))
    else $error("left attenuation readback wrong");

  a_ro_unit_id: assert property (@(posedge core_clk_in)
    disable iff (!rstn_in)
    reg_wr_en_in && reg_index_in == ADM_IDX_UNIT_ID && id_taken_q
    |=> $stable(unit_id_q))
    else $error("read-only identifier changed by write");

  a_step_rate: assert property (@(posedge core_clk_in)
    disable iff (!rstn_in)
    $changed(div_q) |-> $past(fs_tick_in)
      && (div_q == 3'h0 || div_q == $past(div_q) + 3'h1))
    else $error("attenuation step divider moved off a tick");

  a_ramp_step: assert property (@(posedge core_clk_in)
    disable iff (!rstn_in)
    $changed(left_atten_level_out) && $past(is_pcm) && is_pcm
    |-> $past(step_tick))
    else $error("attenuator moved without a step");

  a_mute_code: assert property (@(posedge core_clk_in)
    disable iff (!rstn_in)
    right_mute_out == (right_atten_level_out <= ADM_ATT_MUTE_MAX))
    else $error("mute flag disagrees with level code");

  a_fir_reuse: assert property (@(posedge core_clk_in)
    disable iff (!rstn_in)
    is_bits |=> fir_perf_sel_out == $past(dmf_f)
      && deemph_rate_sel_out == 2'b00)
    else $error("fir select not taken from rate field");

  a_os_reuse: assert property (@(posedge core_clk_in)
    disable iff (!rstn_in)
    !is_bits |=> oversample_rate_sel_out == $past(os_f)
      && fir_rate_sel_out == 2'b00)
    else $error("oversampling select wrong");

  a_bits_zero: assert property (@(posedge core_clk_in)
    disable iff (!rstn_in)
    is_bits |=> !multibit_zero_out_en_out && !rolloff_sel_out)
    else $error("idle field affects bitstream mode");
endmodule : adm_mode_regs

//--- src/adm_pkg.sv
// Constants and types for the audio mode-control register bank
package adm_pkg;
  // Register indices on the control port
  localparam logic [6:0] ADM_IDX_LEFT_ATT = 7'h10;
  localparam logic [6:0] ADM_IDX_RIGHT_ATT = 7'h11;
  localparam logic [6:0] ADM_IDX_FMT_CTRL = 7'h12;
  localparam logic [6:0] ADM_IDX_SPEED_CTRL = 7'h13;
  localparam logic [6:0] ADM_IDX_MODE_CTRL = 7'h14;
  localparam logic [6:0] ADM_IDX_ZERO_CTRL = 7'h15;
  localparam logic [6:0] ADM_IDX_ZERO_FLAG = 7'h16;
  localparam logic [6:0] ADM_IDX_UNIT_ID = 7'h17;

  // Reset values
  localparam logic [7:0] ADM_RST_ATT = 8'hFF;
  localparam logic [7:0] ADM_RST_FMT_CTRL = 8'h50;
  localparam logic [7:0] ADM_RST_SPEED_CTRL = 8'h00;
  localparam logic [7:0] ADM_RST_MODE_CTRL = 8'h00;
  localparam logic [7:0] ADM_RST_ZERO_CTRL = 8'h01;
  localparam logic [4:0] ADM_RST_UNIT_ID = 5'h00;

  // Writable bits; reserved bits store nothing and read as zero
  localparam logic [7:0] ADM_MASK_SPEED_CTRL = 8'hF7;
  localparam logic [7:0] ADM_MASK_MODE_CTRL = 8'h7F;
  localparam logic [7:0] ADM_MASK_ZERO_CTRL = 8'h07;

  // Field positions, format/emphasis/mute register
  localparam int ADM_B_ATTEN_LOAD_ENABLE = 7;
  localparam int ADM_B_FMT_LO = 4;
  localparam int ADM_B_DMF_LO = 2;
  localparam int ADM_B_DME = 1;
  localparam int ADM_B_MUTE = 0;
  // Phase/speed/filter register
  localparam int ADM_B_REV = 7;
  localparam int ADM_B_ATS_LO = 5;
  localparam int ADM_B_OPE = 4;
  localparam int ADM_B_BYPASS_STEREO_SEL = 2;
  localparam int ADM_B_FLT = 1;
  localparam int ADM_B_INFINITE_ZERO_MUTE_EN = 0;
  // Reset/interface/single_channel_mode register
  localparam int ADM_B_SOFT_SYSTEM_RESET = 6;
  localparam int ADM_B_DSD = 5;
  localparam int ADM_B_FILTER_BYPASS_EN = 4;
  localparam int ADM_B_SINGLE_CHANNEL_MODE = 3;
  localparam int ADM_B_SINGLE_CHANNEL_SOURCE = 2;
  localparam int ADM_B_OS_LO = 0;
  // Zero output register
  localparam int ADM_B_DZ_LO = 1;
  localparam int ADM_B_MULTIBIT_ZERO_OUT_EN = 0;

  // Attenuation codes
  localparam logic [7:0] ADM_ATT_FULL = 8'hFF;
  localparam logic [7:0] ADM_ATT_MUTE_MAX = 8'h0E;
  localparam logic [7:0] ADM_ATT_FLOOR = 8'h00;

  // Interface modes of the audio path
  typedef enum logic [1:0] {
    ADM_MODE_PCM = 2'b00,
    ADM_MODE_BYPASS = 2'b01,
    ADM_MODE_BITSTREAM = 2'b10
  } adm_mode_t;
endpackage : adm_pkg
